/* hw/vcle_compare_unit.sv */
// Purpose: Lane-parallel less-or-equal compare, vector or immediate operand
// Assumes: Issue logic holds operands stable in the cycle issueValid is high
// Notes:   One-cycle latency; result and resultValid come from flip-flops
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - True lane gets all ones, else zeros
// - Signed vector form compares two's complement
// - Unsigned vector form compares zero-extended magnitudes
// - Signed immediate sign-extended to element width
// - Unsigned immediate zero-extended to element width
// - Lanes independent, width from element format
// - Operands are integers, never floating point
// - No operand-dependent exception ever raised
module vcle_compare_unit #(
	parameter int VEC_WIDTH = vcle_pkg::VEC_WIDTH_DEFAULT
) (
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	input  wire logic                 clkEnable,
	input  wire logic                 issueValid,
	input  wire logic [1:0]           opSelect,
	input  wire logic [1:0]           element_format,
	input  wire logic [VEC_WIDTH-1:0] first_source_vector,
	input  wire logic [VEC_WIDTH-1:0] second_source_vector,
	input  wire logic [4:0]           signed_imm5,
	input  wire logic [4:0]           unsigned_imm5,
	output logic      [VEC_WIDTH-1:0] dest_vector,
	output logic                      resultValid,
	output logic                      exceptionRaised
);

	localparam int SLOTS = VEC_WIDTH / vcle_pkg::LANE_MAX_WIDTH;

	// Slots are 64 bits wide, so the vector must hold whole slots
	generate
		if (VEC_WIDTH < vcle_pkg::LANE_MAX_WIDTH || VEC_WIDTH % vcle_pkg::LANE_MAX_WIDTH != 0) begin : g_bad_width
			$error("VEC_WIDTH must be a positive multiple of 64");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Immediate broadcast

	function automatic logic [63:0] imm_splat(input logic [4:0] imm, input logic sgn,
		input logic [1:0] fmt);
		logic [63:0] r;
		logic [7:0]  b;
		logic [15:0] h;
		logic [31:0] w;
		logic [63:0] d;
		b = {{3{sgn & imm[4]}}, imm};
		h = {{11{sgn & imm[4]}}, imm};
		w = {{27{sgn & imm[4]}}, imm};
		d = {{59{sgn & imm[4]}}, imm};
		case (fmt)
			vcle_pkg::FMT_BYTE:  r = {8{b}};
			vcle_pkg::FMT_HALF:  r = {4{h}};
			vcle_pkg::FMT_WORD:  r = {2{w}};
			default:             r = d;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Operation decode

	function automatic logic op_uses_imm(input logic [1:0] op);
		return (op == vcle_pkg::OP_IMM_SIGNED) || (op == vcle_pkg::OP_IMM_UNSIGNED);
	endfunction

	function automatic logic op_is_signed(input logic [1:0] op);
		return (op == vcle_pkg::OP_VEC_SIGNED) || (op == vcle_pkg::OP_IMM_SIGNED);
	endfunction

	// Widen one compare bit per element into a full slot mask
	function automatic logic [63:0] lane_mask(input logic [1:0] fmt, input logic [7:0] bLe,
		input logic [3:0] hLe, input logic [1:0] wLe, input logic dLe);
		logic [63:0] m;
		m = '0;
		for (int k = 0; k < 8; k++) begin
			case (fmt)
				vcle_pkg::FMT_BYTE: m[k*8 +: 8] = {8{bLe[k]}};
				vcle_pkg::FMT_HALF: m[k*8 +: 8] = {8{hLe[k/2]}};
				vcle_pkg::FMT_WORD: m[k*8 +: 8] = {8{wLe[k/4]}};
				default:            m[k*8 +: 8] = {8{dLe}};
			endcase
		end
		return m;
	endfunction

	logic        useImm;
	logic        signedCmp;
	logic [63:0] immSlot;
	logic        issueTaken;

	assign useImm     = op_uses_imm(opSelect);
	assign signedCmp  = op_is_signed(opSelect);
	assign issueTaken = clkEnable && issueValid;
	assign immSlot    = (opSelect == vcle_pkg::OP_IMM_SIGNED) ?
		imm_splat(signed_imm5, 1'h1, element_format) :
		imm_splat(unsigned_imm5, 1'h0, element_format);

	////////////////////////////////////////////////////////////////////////////
	// Lane compares

	logic [VEC_WIDTH-1:0] result_d;

	genvar gs;
	generate
		for (gs = 0; gs < SLOTS; gs++) begin : g_slot
			logic [7:0]  byteLe;
			logic [3:0]  halfLe;
			logic [1:0]  wordLe;
			logic        dwordLe;
			logic [63:0] mask;
			logic [63:0] secondSel;

			// Immediate forms replace the second vector in every slot
			assign secondSel = useImm ? immSlot : second_source_vector[gs*64 +: 64];

			vcle_lane_cmp u_cmp (
				.firstSlot  (first_source_vector[gs*64 +: 64]),
				.secondSlot (secondSel),
				.signedCmp  (signedCmp),
				.byteLe     (byteLe),
				.halfLe     (halfLe),
				.wordLe     (wordLe),
				.dwordLe    (dwordLe)
			);

			assign mask = lane_mask(element_format, byteLe, halfLe, wordLe, dwordLe);

			assign result_d[gs*64 +: 64] = mask;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Result register

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			dest_vector <= '0;
		end else if (issueTaken) begin
			dest_vector <= result_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			resultValid <= 1'h0;
		end else if (clkEnable) begin
			resultValid <= issueValid;
		end
	end

	assign exceptionRaised = 1'h0;

endmodule

`default_nettype wire

/* shared/vcle_pkg.sv */
// Purpose: Constants and types for the vector less-or-equal compare unit
// Assumes: Element format codes follow the two-bit format field
// Notes:   Used by the compare unit; its lane compare module takes nothing from it
package vcle_pkg;

	localparam int VEC_WIDTH_DEFAULT = 128;
	localparam int IMM_WIDTH         = 5;
	localparam int LANE_MIN_WIDTH    = 8;
	localparam int LANE_MAX_WIDTH    = 64;
	localparam int FORMAT_WIDTH      = 2;
	localparam int OP_WIDTH          = 2;
	localparam int LATENCY_CYCLES    = 1;

	// Element format field codes
	localparam logic [1:0] FMT_BYTE  = 2'h0;
	localparam logic [1:0] FMT_HALF  = 2'h1;
	localparam logic [1:0] FMT_WORD  = 2'h2;
	localparam logic [1:0] FMT_DWORD = 2'h3;

	// Operation select codes
	localparam logic [1:0] OP_VEC_SIGNED   = 2'h0;
	localparam logic [1:0] OP_VEC_UNSIGNED = 2'h1;
	localparam logic [1:0] OP_IMM_SIGNED   = 2'h2;
	localparam logic [1:0] OP_IMM_UNSIGNED = 2'h3;

	typedef enum logic [0:0] {
		VCLE_IDLE,
		VCLE_BUSY
	} vcle_state_e;

endpackage

/* hw/vcle_lane_cmp.sv */
// Purpose: One 64-bit slot compared at all four element widths
// Assumes: Inputs are already the operands chosen by the top
// Notes:   Purely combinational; all four results offered, top picks one
`timescale 1ns/100ps
`default_nettype none

module vcle_lane_cmp (
	input  wire logic [63:0] firstSlot,
	input  wire logic [63:0] secondSlot,
	input  wire logic        signedCmp,
	output logic      [7:0]  byteLe,
	output logic      [3:0]  halfLe,
	output logic      [1:0]  wordLe,
	output logic             dwordLe
);

	// Leading extension bit makes one signed compare serve both modes
	function automatic logic le_ext(input logic [64:0] a, input logic [64:0] b);
		return $signed(a) <= $signed(b);
	endfunction

	function automatic logic [64:0] ext(input logic [63:0] v, input int w, input logic sgn);
		logic [64:0] r;
		r = '0;
		for (int k = 0; k < 65; k++) begin
			if (k < w)
				r[k] = v[k];
			else
				r[k] = sgn & v[w-1];
		end
		return r;
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_byte
			assign byteLe[gi] = le_ext(ext({56'h0, firstSlot[gi*8 +: 8]}, 8, signedCmp),
				ext({56'h0, secondSlot[gi*8 +: 8]}, 8, signedCmp));
		end
		for (gi = 0; gi < 4; gi++) begin : g_half
			assign halfLe[gi] = le_ext(ext({48'h0, firstSlot[gi*16 +: 16]}, 16, signedCmp),
				ext({48'h0, secondSlot[gi*16 +: 16]}, 16, signedCmp));
		end
		for (gi = 0; gi < 2; gi++) begin : g_word
			assign wordLe[gi] = le_ext(ext({32'h0, firstSlot[gi*32 +: 32]}, 32, signedCmp),
				ext({32'h0, secondSlot[gi*32 +: 32]}, 32, signedCmp));
		end
	endgenerate

	assign dwordLe = le_ext(ext(firstSlot, 64, signedCmp), ext(secondSlot, 64, signedCmp));

endmodule

`default_nettype wire

/* test/vcle_compare_props.sv */
// Purpose: Port assertions for the compare unit
// Assumes: Low lanes stand for the rest
// Notes:   Bound below
`timescale 1ns/100ps
`default_nettype none
module vcle_compare_props #(parameter int W = 128) (
	input wire logic         clk,
	input wire logic         reset_n,
	input wire logic         clkEnable,
	input wire logic         issueValid,
	input wire logic [1:0]   opSelect,
	input wire logic [1:0]   element_format,
	input wire logic [W-1:0] first_source_vector,
	input wire logic [W-1:0] second_source_vector,
	input wire logic [4:0]   signed_imm5,
	input wire logic [4:0]   unsigned_imm5,
	input wire logic [W-1:0] dest_vector,
	input wire logic         resultValid,
	input wire logic         exceptionRaised
);
	logic [63:0] pa, pb;
	logic [4:0]  pk;
	// Previous edge: taken flag, op, format, low operands
	always_ff @(posedge clk) begin
		pk <= {reset_n & clkEnable & issueValid, opSelect, element_format};
		pa <= first_source_vector[63:0];
		pb <= second_source_vector[63:0];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	AST_NO_EXC: assert property (!exceptionRaised) else $error("exc");
	AST_VALID: assert property (pk[4] |-> resultValid) else $error("valid");
	AST_IDLE: assert property (clkEnable && !issueValid |=> !resultValid) else $error("idle");
	AST_FREEZE: assert property (!clkEnable |=> $stable(dest_vector)) else $error("freeze");
	AST_VS: assert property (pk == 5'h13 |-> dest_vector[63:0] == {64{$signed(pa) <= $signed(pb)}})
		else $error("vs");
	AST_VU: assert property (pk == 5'h16 |-> dest_vector[63:32] == {32{pa[63:32] <= pb[63:32]}})
		else $error("vu");
	AST_IS: assert property (pk == 5'h18 |->
		dest_vector[7:0] == {8{$signed(pa[7:0]) <= $signed($past(signed_imm5))}}) else $error("is");
	AST_IU: assert property (pk == 5'h1d |-> dest_vector[15:0] == {16{pa[15:0] <= $past(unsigned_imm5)}})
		else $error("iu");
	cover property (pk[4] ##1 pk[4]);
	cover property (pk[4] ##1 !clkEnable);
	cover property (pk == 5'h18);
endmodule
bind vcle_compare_unit vcle_compare_props #(.W(VEC_WIDTH)) u_props (
	.clk                  (clk),
	.reset_n              (reset_n),
	.clkEnable            (clkEnable),
	.issueValid           (issueValid),
	.opSelect             (opSelect),
	.element_format       (element_format),
	.first_source_vector  (first_source_vector),
	.second_source_vector (second_source_vector),
	.signed_imm5          (signed_imm5),
	.unsigned_imm5        (unsigned_imm5),
	.dest_vector          (dest_vector),
	.resultValid          (resultValid),
	.exceptionRaised      (exceptionRaised)
);
`default_nettype wire

/* test/vcle_issue_model.sv */
// Purpose: Issue stage driving operands and stall
// Assumes: Changes just after the rising edge
// Notes:   Idle vector operands show the inverse of the last
`timescale 1ns/100ps
`default_nettype none
module vcle_issue_model (
	input  wire logic    clk,
	output logic         ce,
	output logic         iv,
	output logic [1:0]   op,
	output logic [1:0]   fm,
	output logic [127:0] a,
	output logic [127:0] b,
	output logic [4:0]   s,
	output logic [4:0]   u
);
	initial {ce, iv, op, fm, a, b, s, u} = '0;
	task automatic drive(input logic v, e, logic [1:0] o, f, logic [127:0] x, y, logic [4:0] sx, ux);
		@(posedge clk);
		ce <= e;
		iv <= v;
		op <= o;
		fm <= f;
		a <= v ? x : ~a;
		b <= v ? y : ~b;
		s <= sx;
		u <= ux;
	endtask
endmodule
`default_nettype wire

/* test/tb_top.sv */
// Purpose: Self-checking bench for the compare unit
// Assumes: One-cycle latency, stall freezes outputs
// Notes:   Every op and format first, then random
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic         clk = 1'h0, reset_n = 1'h0, ce, iv, rv, ex, tk = 1'h0, en = 1'h0;
	logic [1:0]   op, fm;
	logic [127:0] fa, fb, dv, xv, a, b;
	logic [4:0]   si, su;
	logic [31:0]  rnd = 32'h47;
	int           errCount = 0, checkCount = 0, cyc = 0;
	// About three times what the scenarios need
	localparam int CYCLE_LIMIT = 1000;
	vcle_compare_unit DUT (.clk(clk), .reset_n(reset_n), .clkEnable(ce), .issueValid(iv), .opSelect(op),
		.element_format(fm), .first_source_vector(fa), .second_source_vector(fb), .signed_imm5(si),
		.unsigned_imm5(su), .dest_vector(dv), .resultValid(rv), .exceptionRaised(ex));
	vcle_issue_model model (.clk(clk), .ce(ce), .iv(iv), .op(op), .fm(fm), .a(fa), .b(fb), .s(si), .u(su));
	initial forever #2.5 clk = ~clk;
	function automatic logic [31:0] rn();
		rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
		return rnd;
	endfunction
	// Lanes widened to 65 bits so one signed compare serves all forms
	function automatic logic [127:0] ref_le(logic [1:0] o, f, logic [127:0] x, y, logic [4:0] s, u);
		logic [127:0] r;
		logic [64:0]  p, q;
		int           w = 8 << f;
		for (int i = 0; i < 128 / w; i++) begin
			for (int k = 0; k < 65; k++) begin
				p[k] = k < w ? x[i*w+k] : !o[0] & x[i*w+w-1];
				q[k] = o[1] ? (k < 5 ? (o[0] ? u[k] : s[k]) : !o[0] & s[4]) : k < w ? y[i*w+k] : !o[0] & y[i*w+w-1];
			end
			for (int k = 0; k < w; k++)
				r[i*w+k] = $signed(p) <= $signed(q);
		end
		return r;
	endfunction
	task automatic chkVec(string n, logic [127:0] e, g);
		checkCount++;
		if (e !== g) begin
			errCount++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chkBit(string n, logic e, g);
		checkCount++;
		if (e !== g) begin
			errCount++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wrapUp();
		$display("Checks %0d, errors %0d", checkCount, errCount);
		if (errCount == 0 && checkCount > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > CYCLE_LIMIT) begin
			errCount++;
			wrapUp();
		end
	end
	always @(posedge clk) begin
		if (tk)
			chkVec("dest", xv, dv);
		if (en)
			chkBit("valid", tk, rv);
		chkBit("exc", 1'h0, ex);
		tk <= reset_n & ce & iv;
		en <= ce | !reset_n;
		xv <= ref_le(op, fm, fa, fb, si, su);
	end
	initial begin
		repeat (5) @(posedge clk);
		reset_n <= 1'h1;
		for (int i = 0; i < 300; i++) begin
			a = i < 32 && i[4] ? {16{8'h80}} : {rn(), rn(), rn(), rn()};
			b = i % 8 ? {rn(), rn(), rn(), rn()} : a;
			model.drive(i < 32 || |rnd[1:0], i < 32 || |rnd[4:2], i < 32 ? i[1:0] : rnd[6:5],
				i < 32 ? i[3:2] : rnd[8:7], a, b, rnd[13:9], rnd[18:14]);
			reset_n <= i != 150;
		end
		repeat (3) @(posedge clk);
		wrapUp();
	end
endmodule
`default_nettype wire
